// ### logic/usb_rx_ep_pkg.sv
/*
  Shared constants and types for the receive endpoint control block: APB
  offsets, control word field positions, interrupt bit layout and the
  packed carriers for receive events and FIFO bytes.
  Assumes a 32-bit APB slave and an 11-bit maximum packet size.
*/
package usb_rx_ep_pkg;

  // APB byte offsets, one aligned word each.
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h0C;

  // Control word field positions.
  localparam int AUTO_CLEAR_BIT   = 31;
  localparam int ISO_AUTOREQ_BIT  = 30;
  localparam int DMA_ENABLE_BIT   = 29;
  localparam int NYET_PID_ERROR_FLAG_BIT  = 28;
  localparam int DMA_MODE_BIT     = 27;
  localparam int REQ_PACKET_BIT   = 21;
  localparam int PKT_READY_BIT    = 16;
  localparam int PACKET_MULTIPLIER_LSB         = 11;
  localparam int PACKET_MULTIPLIER_WIDTH       = 5;
  localparam int MAXP_WIDTH       = 11;

  // Interrupt status layout.
  localparam int IRQ_WIDTH        = 3;
  localparam int IRQ_RX_PACKET    = 0;
  localparam int IRQ_PID_ERROR    = 1;
  localparam int IRQ_AUTO_CLEARED = 2;

  // Chunk size toward the DMA engine, in bytes.
  localparam int CHUNK_BYTES      = 4;
  localparam logic [2:0] CHUNK_BYTES_W = 3'h4;

  // Reset values.
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [MAXP_WIDTH-1:0] MAXP_RESET = 11'h000;

  // One received packet, announced by the USB receive logic.
  typedef struct packed {
    logic                  valid;
    logic [MAXP_WIDTH-1:0] len;
    logic                  iso;
    logic                  pid_err;
  } rx_evt_t;

  // One byte leaving the receive FIFO.
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } fifo_byte_t;

  // Packer states.
  typedef enum logic [0:0] {PACK_FILL, PACK_HOLD} pack_state_t;

endpackage

// ### logic/byte_chunk_packer.sv
/*
  Packs receive FIFO bytes into 32-bit chunks for the DMA engine.
  Assumes the byte source holds a byte until byte_ready is high and marks
  the final byte of a packet with last; a short tail leaves as a partial chunk.
*/
`timescale 1ns/1ps
module byte_chunk_packer
  import usb_rx_ep_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire fifo_byte_t  byte_in,
  output logic             byte_ready,
  output logic             word_valid,
  output logic [31:0]      word_data,
  output logic [2:0]       word_bytes,
  input  wire logic        word_ready
);

  pack_state_t state_reg;       // Filling a chunk or holding it out.
  logic [31:0] word_reg;        // Chunk being assembled, byte 0 lowest.
  logic [2:0]  count_reg;       // Bytes held in the chunk.

  wire take      = byte_in.valid && byte_ready;
  wire chunk_end = take && (byte_in.last || count_reg == CHUNK_BYTES_W - 3'h1);

  // Bytes are refused while a finished chunk waits, so the FIFO stalls.
  assign byte_ready = (state_reg == PACK_FILL);
  assign word_valid = (state_reg == PACK_HOLD);
  assign word_data  = word_reg;
  assign word_bytes = count_reg;

  // Byte lanes fill from the bottom; a chunk leaves on its fourth byte or last.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= PACK_FILL;
      word_reg  <= ZERO_WORD;
      count_reg <= 3'h0;
    end
    else
    begin
      case (state_reg)
        PACK_FILL:
        begin
          if (take)
          begin
            word_reg[count_reg[1:0]*8 +: 8] <= byte_in.data;
            count_reg <= count_reg + 3'h1;
          end
          if (chunk_end)
            state_reg <= PACK_HOLD;
        end
        default:
        begin
          if (word_ready)
          begin
            state_reg <= PACK_FILL;
            word_reg  <= ZERO_WORD;
            count_reg <= 3'h0;
          end
        end
      endcase
    end
  end

endmodule

// ### logic/usb_rx_endpoint_control.sv
/*
  Receive-side control and status of one indexed USB endpoint, reached
  over APB: auto-clear of packet-ready, host auto-request, transfer type,
  DMA request gating and mode, NYET suppression and host PID error flag.
  Assumes the USB receive logic, the FIFO and the DMA engine run on pclk.
*/
// Summary of operation
// RL1: Auto-clear packet-ready after full-size packet unloaded.
// RL2: Software clears packet-ready after short packets.
// RL3: DMA unloads FIFO in 4-byte chunks.
// RL4: Avoid auto-clear on high-bandwidth isochronous endpoints; auto_clr here ignores transfer type and packet multiplier.
// RL5: Device mode bit 30 selects isochronous transfers.
// RL6: Host auto-request sets request on ready clear.
// RL7: Short packet clears auto-request bit.
// RL8: Bit 29 gates endpoint DMA requests.
// RL9: Suppression sends no NYET, ACKs everything.
// RL10: Suppression matters only in high-speed bulk/interrupt.
// RL11: Host mode bit 28 flags isochronous PID errors.
// RL12: Bit 27 selects DMA request mode.
// RL13: Eleven-bit max packet size drives auto-clear compare.
`timescale 1ns/1ps
module usb_rx_endpoint_control
  import usb_rx_ep_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        host_mode,
  input  wire logic        high_speed,
  input  wire rx_evt_t     rx_evt,
  input  wire logic        fifo_full,
  output logic             hs_nyet,
  output logic             request_packet,
  input  wire fifo_byte_t  fifo_byte,
  output logic             fifo_byte_ready,
  output logic             dma_req,
  output logic [31:0]      dma_data,
  input  wire logic        dma_ack,
  output logic             irq
);

  // Control word storage.
  logic                  auto_clear_reg;     // Auto-clear of packet-ready.
  logic                  iso_autoreq_reg;    // Isochronous (device) or auto-request (host).
  logic                  dma_enable_reg;     // DMA request gate.
  logic                  nyet_suppress_reg;  // Device-mode NYET suppression.
  logic                  pid_error_flag_reg; // Host-mode PID error status.
  logic                  dma_mode_reg;       // DMA request mode select.
  logic                  req_packet_reg;     // Host request for an IN packet.
  logic                  pkt_ready_reg;      // A received packet waits in the FIFO.
  logic [PACKET_MULTIPLIER_WIDTH-1:0] packet_multiplier_reg;           // Packet multiplier, stored only.
  logic [MAXP_WIDTH-1:0] maxp_reg;           // Maximum packet size in bytes.
  logic [MAXP_WIDTH-1:0] pkt_len_reg;        // Length of the waiting packet.
  logic [MAXP_WIDTH:0]   unloaded_reg;       // Bytes handed to the DMA engine.
  logic [IRQ_WIDTH-1:0]  irq_status_reg;     // Sticky event bits.
  logic [IRQ_WIDTH-1:0]  irq_enable_reg;     // Interrupt enables.
  logic [31:0]           prdata_reg;         // Read data captured in setup.

  // APB decode; the slave always answers in the first access cycle.
  wire setup     = psel && !penable;
  wire access    = psel && penable;
  wire hit_ctrl  = (paddr == CTRL_OFFSET);
  wire hit_stat  = (paddr == IRQ_STATUS_OFFSET);
  wire hit_en    = (paddr == IRQ_ENABLE_OFFSET);
  wire hit_clr   = (paddr == IRQ_CLEAR_OFFSET);
  wire mapped    = hit_ctrl || hit_stat || hit_en || hit_clr;
  wire wr_ctrl   = access && pwrite && hit_ctrl;
  wire wr_en     = access && pwrite && hit_en;
  wire wr_clr    = access && pwrite && hit_clr;

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = prdata_reg;

  // Bit 28 reads the PID error flag in host mode and the suppress bit otherwise.
  wire bit28_view = host_mode ? pid_error_flag_reg : nyet_suppress_reg;
  wire [31:0] ctrl_view = {auto_clear_reg, iso_autoreq_reg, dma_enable_reg, bit28_view,
                           dma_mode_reg, 5'h00, req_packet_reg, 4'h0, pkt_ready_reg,
                           packet_multiplier_reg, maxp_reg};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_view :
                       hit_stat ? {29'h0000_0000, irq_status_reg} :
                       hit_en   ? {29'h0000_0000, irq_enable_reg} : ZERO_WORD;

  // Chunk packer toward the DMA engine.
  logic        word_valid;
  logic [31:0] word_data;
  logic [2:0]  word_bytes;
  wire         word_taken = dma_req && dma_ack;

  byte_chunk_packer u_packer (
    .pclk       (pclk),
    .presetn    (presetn),
    .byte_in    (fifo_byte),
    .byte_ready (fifo_byte_ready),
    .word_valid (word_valid),
    .word_data  (word_data),
    .word_bytes (word_bytes),
    .word_ready (word_taken)
  );

  // Mode 0 asks only for a packet in hand; mode 1 asks for any chunk.
  assign dma_req  = dma_enable_reg && word_valid && (dma_mode_reg || pkt_ready_reg); // RL8 RL12
  assign dma_data = word_data; // RL3

  // Auto-clear fires when the last chunk of a full-size packet leaves.
  wire [MAXP_WIDTH:0] unloaded_after = unloaded_reg + {{(MAXP_WIDTH-2){1'b0}}, word_bytes};
  wire full_size  = (pkt_len_reg == maxp_reg); // RL13
  wire auto_clr   = auto_clear_reg && pkt_ready_reg && full_size && word_taken
                    && (unloaded_after >= {1'b0, pkt_len_reg}); // RL1

  // Software clears packet-ready by writing zero; writing one is ignored.
  wire sw_clr_rdy = wr_ctrl && !pwdata[PKT_READY_BIT]; // RL2
  // A packet landing in the same cycle keeps ready set, so no clear is seen.
  wire rdy_clear  = (auto_clr || sw_clr_rdy) && pkt_ready_reg && !rx_evt.valid;
  wire short_pkt  = rx_evt.valid && (rx_evt.len < maxp_reg);
  wire pid_event  = host_mode && rx_evt.valid && rx_evt.iso && rx_evt.pid_err;

  // Device-mode NYET only for high-speed bulk/interrupt without suppression.
  assign hs_nyet = !host_mode && !iso_autoreq_reg && high_speed
                   && !nyet_suppress_reg && fifo_full; // RL5 RL9 RL10
  assign request_packet = req_packet_reg;

  wire [IRQ_WIDTH-1:0] irq_events = {auto_clr, pid_event, rx_evt.valid};

  // APB read data is captured in the setup cycle and held for the access.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= ZERO_WORD;
    else if (setup && !pwrite)
      prdata_reg <= rd_mux;
  end

  // Plain software-owned control fields.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      auto_clear_reg    <= 1'b0;
      dma_enable_reg    <= 1'b0;
      dma_mode_reg      <= 1'b0;
      nyet_suppress_reg <= 1'b0;
      packet_multiplier_reg          <= '0;
      maxp_reg          <= MAXP_RESET;
    end
    else if (wr_ctrl)
    begin
      auto_clear_reg <= pwdata[AUTO_CLEAR_BIT];
      dma_enable_reg <= pwdata[DMA_ENABLE_BIT];
      dma_mode_reg   <= pwdata[DMA_MODE_BIT];
      // In host mode bit 28 is status, so the suppress bit keeps its value.
      if (!host_mode)
        nyet_suppress_reg <= pwdata[NYET_PID_ERROR_FLAG_BIT];
      packet_multiplier_reg <= pwdata[PACKET_MULTIPLIER_LSB +: PACKET_MULTIPLIER_WIDTH];
      maxp_reg <= pwdata[MAXP_WIDTH-1:0];
    end
  end

  // Bit 30: written by software, cleared by hardware on a short host packet.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      iso_autoreq_reg <= 1'b0;
    else if (host_mode && short_pkt)
      iso_autoreq_reg <= 1'b0; // RL7
    else if (wr_ctrl)
      iso_autoreq_reg <= pwdata[ISO_AUTOREQ_BIT];
  end

  // Packet-ready: a new packet sets it and wins over any clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pkt_ready_reg <= 1'b0;
      pkt_len_reg   <= MAXP_RESET;
    end
    else if (rx_evt.valid)
    begin
      pkt_ready_reg <= 1'b1;
      pkt_len_reg   <= rx_evt.len;
    end
    else if (rdy_clear)
      pkt_ready_reg <= 1'b0; // RL1
  end

  // Byte count of the current packet already handed to the DMA engine.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      unloaded_reg <= '0;
    else if (rx_evt.valid)
      unloaded_reg <= '0;
    else if (word_taken)
      unloaded_reg <= unloaded_after;
  end

  // Host request: auto-request re-arms it on every packet-ready clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_packet_reg <= 1'b0;
    else if (host_mode && iso_autoreq_reg && rdy_clear)
      req_packet_reg <= 1'b1; // RL6
    else if (rx_evt.valid || !host_mode)
      req_packet_reg <= 1'b0;
    else if (wr_ctrl && pwdata[REQ_PACKET_BIT])
      req_packet_reg <= 1'b1;
  end

  // PID error flag: set by hardware, cleared by writing zero in host mode.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pid_error_flag_reg <= 1'b0;
    else if (pid_event)
      pid_error_flag_reg <= 1'b1; // RL11
    else if (wr_ctrl && host_mode && !pwdata[NYET_PID_ERROR_FLAG_BIT])
      pid_error_flag_reg <= 1'b0;
  end

  // Interrupts: events set sticky bits; a set outweighs a same-cycle clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status_reg <= '0;
      irq_enable_reg <= '0;
    end
    else
    begin
      irq_status_reg <= irq_events | (irq_status_reg & ~(wr_clr ? pwdata[IRQ_WIDTH-1:0] : '0));
      if (wr_en)
        irq_enable_reg <= pwdata[IRQ_WIDTH-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  // Checks kept beside the logic they watch.
  sequence s_full_unload;
    auto_clear_reg && pkt_ready_reg && full_size && word_taken
      && (unloaded_after >= {1'b0, pkt_len_reg}) && !rx_evt.valid;
  endsequence

  sequence s_host_rearm;
    host_mode && iso_autoreq_reg && pkt_ready_reg && sw_clr_rdy;
  endsequence

  property p_auto_clear;
    @(posedge pclk) disable iff (!presetn)
    s_full_unload |=> !pkt_ready_reg;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("packet-ready not auto-cleared"); // RL1

  property p_no_auto_clear_short;
    @(posedge pclk) disable iff (!presetn)
    pkt_ready_reg && (pkt_len_reg < maxp_reg) && !wr_ctrl |=> pkt_ready_reg || $past(rx_evt.valid);
  endproperty
  a_no_auto_clear_short: assert property (p_no_auto_clear_short) else $error("short packet auto-cleared"); // RL2

  property p_chunk_hold;
    @(posedge pclk) disable iff (!presetn)
    dma_req && !dma_ack |=> word_valid && $stable(dma_data);
  endproperty
  a_chunk_hold: assert property (p_chunk_hold) else $error("DMA chunk changed before taken"); // RL3

  property p_iso_no_nyet;
    @(posedge pclk) disable iff (!presetn)
    !host_mode && iso_autoreq_reg |-> !hs_nyet;
  endproperty
  a_iso_no_nyet: assert property (p_iso_no_nyet) else $error("NYET on isochronous endpoint"); // RL5

  property p_auto_request;
    @(posedge pclk) disable iff (!presetn)
    s_host_rearm ##0 !rx_evt.valid |=> req_packet_reg [*1] ##1 (req_packet_reg || $past(rx_evt.valid));
  endproperty
  a_auto_request: assert property (p_auto_request) else $error("request not re-armed"); // RL6

  property p_short_clears_autoreq;
    @(posedge pclk) disable iff (!presetn)
    host_mode && short_pkt |=> !iso_autoreq_reg;
  endproperty
  a_short_clears_autoreq: assert property (p_short_clears_autoreq) else $error("auto-request kept"); // RL7

  property p_dma_gate;
    @(posedge pclk) disable iff (!presetn)
    !dma_enable_reg |-> !dma_req;
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("DMA request while disabled"); // RL8

  property p_nyet_suppress;
    @(posedge pclk) disable iff (!presetn)
    nyet_suppress_reg && !host_mode && high_speed && fifo_full |-> !hs_nyet;
  endproperty
  a_nyet_suppress: assert property (p_nyet_suppress) else $error("NYET while suppressed"); // RL9

  property p_pid_error;
    @(posedge pclk) disable iff (!presetn)
    pid_event |=> pid_error_flag_reg ##0 (ctrl_view[NYET_PID_ERROR_FLAG_BIT] || !host_mode);
  endproperty
  a_pid_error: assert property (p_pid_error) else $error("PID error not flagged"); // RL11

  property p_dma_mode0;
    @(posedge pclk) disable iff (!presetn)
    dma_req && !dma_mode_reg |-> pkt_ready_reg;
  endproperty
  a_dma_mode0: assert property (p_dma_mode0) else $error("mode 0 request without packet"); // RL12

endmodule

// ### testbench/usb_rx_far_model.sv
/*
  Far-side model of the receive endpoint: FIFO byte source and DMA engine.
  Assumes the block takes a byte on valid&ready and a chunk on req&ack.
*/
`timescale 1ns/1ps
module usb_rx_far_model
  import usb_rx_ep_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic [10:0] len,
  input  wire logic        slow,
  output fifo_byte_t       fifo_byte,
  input  wire logic        fifo_byte_ready,
  input  wire logic        dma_req,
  input  wire logic [31:0] dma_data,
  output logic             dma_ack,
  output logic [3:0]       words_got,
  output logic [31:0]      got_w [16]
);
  logic [10:0] idx_reg;   // Next byte index; each byte carries its index.
  logic [10:0] total_reg; // Bytes in the packet being offered.
  logic        more;      // A byte is on offer.
  assign more = idx_reg < total_reg;
  // An idle data line shows a changed value, so a stale byte never passes.
  assign fifo_byte = {more, idx_reg == total_reg - 11'h001,
                      more ? idx_reg[7:0] : ~idx_reg[7:0]};
  // The source advances per taken byte; a slow engine acks every other cycle.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      idx_reg   <= 11'h000;
      total_reg <= 11'h000;
      dma_ack   <= 1'b0;
      words_got <= 4'h0;
    end
    else
    begin
      if (go)
      begin
        idx_reg   <= 11'h000;
        total_reg <= len;
      end
      else if (more && fifo_byte_ready)
        idx_reg <= idx_reg + 11'h001;
      dma_ack <= slow ? ~dma_ack : 1'b1;
      if (dma_req && dma_ack)
        words_got <= words_got + 4'h1;
    end
  // Every accepted chunk is logged in arrival order.
  always_ff @(posedge pclk)
    if (dma_req && dma_ack)
      got_w[words_got] <= dma_data;
endmodule

// ### testbench/usb_rx_endpoint_control_tb.sv
/*
  Self-checking bench for the receive endpoint control block.
  Assumes zero-wait APB and the far-side model for FIFO and DMA traffic.
*/
`timescale 1ns/1ps
module usb_rx_endpoint_control_tb
  import usb_rx_ep_pkg::*;
;
  localparam logic [31:0] BIT0 = 32'h0000_0001; // Single flag set.
  localparam logic [31:0] RDY  = 32'h0001_0000; // Packet-ready field.
  localparam logic [31:0] ALL  = 32'hFFFF_FFFF; // Whole-word mask.
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = ZERO_WORD;
  logic        host_mode = 1'b0, high_speed = 1'b0, fifo_full = 1'b0;
  rx_evt_t     rx_evt = '0;
  logic        go = 1'b0, slow = 1'b0;
  logic [10:0] len = 11'h000;
  logic [31:0] prdata, dma_data, rd, got_w [16];
  logic        pready, pslverr, hs_nyet, request_packet, err;
  logic        fifo_byte_ready, dma_req, dma_ack, irq;
  logic [3:0]  words_got;
  fifo_byte_t  fifo_byte;
  int          fails = 0, checks_done = 0, cycles = 0;
  // Free-running bus clock.
  always #50 pclk = ~pclk;
  usb_rx_endpoint_control usb_rx_endpoint_control_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_mode(host_mode),
    .high_speed(high_speed), .rx_evt(rx_evt), .fifo_full(fifo_full), .hs_nyet(hs_nyet),
    .request_packet(request_packet), .fifo_byte(fifo_byte),
    .fifo_byte_ready(fifo_byte_ready), .dma_req(dma_req), .dma_data(dma_data),
    .dma_ack(dma_ack), .irq(irq));
  usb_rx_far_model usb_rx_far_model_inst (.pclk(pclk), .presetn(presetn), .go(go),
    .len(len), .slow(slow), .fifo_byte(fifo_byte), .fifo_byte_ready(fifo_byte_ready),
    .dma_req(dma_req), .dma_data(dma_data), .dma_ack(dma_ack), .words_got(words_got),
    .got_w(got_w));
  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("Checks made %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Case-equality compare, so an unknown never counts as a match.
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads a register and compares the masked fields.
  task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, ZERO_WORD);
    chk(rd & m, e);
  endtask
  // Announces one received packet as a one-cycle pulse.
  task pkt(input logic [10:0] l, input logic i, input logic p);
    @(posedge pclk);
    rx_evt <= '{1'b1, l, i, p};
    @(posedge pclk);
    rx_evt <= '0;
    @(posedge pclk);
  endtask
  // Starts the FIFO source on a packet of l bytes.
  task send(input logic [10:0] l, input logic s);
    @(posedge pclk);
    go   <= 1'b1;
    len  <= l;
    slow <= s;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  // Waits for the DMA log to reach n chunks; the timeout bounds it.
  task wait_words(input logic [3:0] n);
    while (words_got !== n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // Reset values, a clear register that reads as zero and an unmapped address.
  task s_reset;
    rdchk(CTRL_OFFSET, ALL, ZERO_WORD);
    rdchk(IRQ_STATUS_OFFSET, ALL, ZERO_WORD);
    rdchk(IRQ_ENABLE_OFFSET, ALL, ZERO_WORD);
    rdchk(IRQ_CLEAR_OFFSET, ALL, ZERO_WORD);
    chk(irq, ZERO_WORD);
    chk(pready, BIT0);
    apb(1'b0, 8'h10, ZERO_WORD);
    chk(err, BIT0);
    chk(rd, ZERO_WORD);
  endtask
  // Control fields hold what was written; a written 1 cannot set ready.
  task s_fields;
    apb(1'b1, CTRL_OFFSET, 32'hF801_FFFF);
    rdchk(CTRL_OFFSET, ALL, 32'hF800_FFFF);
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h0000_0007);
    rdchk(IRQ_STATUS_OFFSET, ALL, ZERO_WORD);
    apb(1'b1, CTRL_OFFSET, ZERO_WORD);
  endtask
  // NYET only while high speed, not isochronous and not suppressed; the FIFO is held full throughout.
  task s_nyet;
    high_speed <= 1'b1;
    fifo_full  <= 1'b1;
    apb(1'b1, CTRL_OFFSET, ZERO_WORD);
    @(negedge pclk);
    chk(hs_nyet, BIT0);
    apb(1'b1, CTRL_OFFSET, 32'h1000_0000);
    @(negedge pclk);
    chk(hs_nyet, ZERO_WORD);
    apb(1'b1, CTRL_OFFSET, 32'h4000_0000);
    @(negedge pclk);
    chk(hs_nyet, ZERO_WORD);
    apb(1'b1, CTRL_OFFSET, ZERO_WORD);
    high_speed <= 1'b0;
    @(negedge pclk);
    chk(hs_nyet, ZERO_WORD);
  endtask
  // A full-size packet drained by DMA clears ready by itself.
  task s_auto;
    apb(1'b1, IRQ_ENABLE_OFFSET, 32'h0000_0007);
    apb(1'b1, CTRL_OFFSET, 32'hA800_0008);
    pkt(11'h008, 1'b0, 1'b0);
    rdchk(CTRL_OFFSET, RDY, RDY);
    send(11'h008, 1'b0);
    wait_words(4'h2);
    chk(got_w[0], 32'h0302_0100);
    chk(got_w[1], 32'h0706_0504);
    rdchk(CTRL_OFFSET, RDY, ZERO_WORD);
    rdchk(IRQ_STATUS_OFFSET, ALL, 32'h0000_0005);
    apb(1'b1, IRQ_ENABLE_OFFSET, ZERO_WORD);
    @(negedge pclk);
    chk(irq, ZERO_WORD);
    apb(1'b1, IRQ_ENABLE_OFFSET, 32'h0000_0007);
    @(negedge pclk);
    chk(irq, BIT0);
    apb(1'b1, IRQ_CLEAR_OFFSET, 32'h0000_0007);
    @(negedge pclk);
    chk(irq, ZERO_WORD);
    rdchk(IRQ_STATUS_OFFSET, ALL, ZERO_WORD);
  endtask
  // A short packet leaves a partial chunk and ready stays set.
  task s_short;
    pkt(11'h003, 1'b0, 1'b0);
    send(11'h003, 1'b1);
    wait_words(4'h3);
    chk(got_w[2], 32'h0002_0100);
    rdchk(CTRL_OFFSET, RDY, RDY);
    apb(1'b1, CTRL_OFFSET, 32'hA800_0008);
    rdchk(CTRL_OFFSET, RDY, ZERO_WORD);
    apb(1'b1, IRQ_CLEAR_OFFSET, 32'h0000_0007);
  endtask
  // Disabled DMA raises no request; mode 0 waits for a ready packet.
  task s_gate;
    apb(1'b1, CTRL_OFFSET, 32'h0000_0008);
    send(11'h004, 1'b0);
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    chk(dma_req, ZERO_WORD);
    chk(words_got, 32'h0000_0003);
    apb(1'b1, CTRL_OFFSET, 32'h2000_0008);
    @(negedge pclk);
    chk(dma_req, ZERO_WORD);
    pkt(11'h004, 1'b0, 1'b0);
    wait_words(4'h4);
    chk(got_w[3], 32'h0302_0100);
    apb(1'b1, CTRL_OFFSET, ZERO_WORD);
  endtask
  // Host: auto-request on ready clear, cancelled by a short packet; PID error.
  task s_host;
    host_mode <= 1'b1;
    apb(1'b1, CTRL_OFFSET, 32'h4000_0008);
    pkt(11'h008, 1'b0, 1'b0);
    rdchk(CTRL_OFFSET, 32'h0021_0000, RDY);
    apb(1'b1, CTRL_OFFSET, 32'h4000_0008);
    @(negedge pclk);
    chk(request_packet, BIT0);
    pkt(11'h003, 1'b0, 1'b0);
    rdchk(CTRL_OFFSET, 32'h4020_0000, ZERO_WORD);
    pkt(11'h008, 1'b1, 1'b1);
    rdchk(CTRL_OFFSET, 32'h1000_0000, 32'h1000_0000);
    rdchk(IRQ_STATUS_OFFSET, 32'h0000_0002, 32'h0000_0002);
    apb(1'b1, CTRL_OFFSET, ZERO_WORD);
    rdchk(CTRL_OFFSET, 32'h1000_0000, ZERO_WORD);
    host_mode <= 1'b0;
  endtask
  // A hang ends the run as a mismatch; tests need about 170 cycles.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      end_sim;
    end
  end
  // Reset for three cycles, then the scenarios in order.
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    s_reset;
    s_fields;
    s_nyet;
    s_auto;
    s_short;
    s_gate;
    s_host;
    end_sim;
  end
endmodule
